//--- bench/mp_pin_partner.sv
// External pin model: drives or releases each multipurpose pin
`timescale 1ns/100ps
module mp_pin_partner
  import mp_pin_pkg::*;
(
  input  wire logic                            core_clk,
  input  wire logic [mp_pin_pkg::NUM_PINS-1:0] pin_out,
  input  wire logic [mp_pin_pkg::NUM_PINS-1:0] pin_oe,
  input  wire logic [mp_pin_pkg::NUM_PINS-1:0] pin_pullup,
  input  wire logic [mp_pin_pkg::NUM_PINS-1:0] ext_val,
  input  wire logic [mp_pin_pkg::NUM_PINS-1:0] ext_en,
  output logic [mp_pin_pkg::NUM_PINS-1:0]      pin_in
);
  logic [NUM_PINS-1:0] float_q = '0;

  // --------------------------------------------------------------------
  // Wire resolution
  // --------------------------------------------------------------------
  // A released pin without pull-up never holds its old level
  always_ff @(posedge core_clk)
  begin
    float_q <= ~float_q;
  end

  always_comb
  begin
    pin_in = (pin_oe & pin_out)
           | (~pin_oe & ext_en & ext_val)
           | (~pin_oe & ~ext_en & (pin_pullup | float_q));
  end
endmodule : mp_pin_partner

//--- bench/multipurpose_pin_config_tb.sv
// Self-checking testbench for the multipurpose pin configuration block
`timescale 1ns/100ps
module multipurpose_pin_config_tb;
  import mp_pin_pkg::*;
  logic                core_clk = 1'b0;
  logic                reset    = 1'b1;
  logic [ADDR_W-1:0]   addr     = '0;
  logic [DATA_W-1:0]   wdata    = '0;
  logic                wr_en    = 1'b0;
  logic                rd_en    = 1'b0;
  logic [DATA_W-1:0]   rdata;
  logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe, pin_pullup, alt_function_enable;
  logic [NUM_PINS-1:0] dsp_pin_value, pdm_data_sel, pdm_data;
  logic [NUM_PINS-1:0] gpio_out_value = '0;
  logic                panic_flag     = 1'b0;
  logic [6:1]          ss_lines       = '0;
  logic [NUM_PINS-1:0] ext_val        = '0;
  logic [NUM_PINS-1:0] ext_en         = '0;
  logic [15:0]         rv;
  int                  err_total = 0;
  int                  compares  = 0;
  int                  cycles    = 0;

  always #50 core_clk = ~core_clk;

  mp_pin_config DUT (.core_clk(core_clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup), .alt_function_enable(alt_function_enable),
    .dsp_pin_value(dsp_pin_value), .pdm_data_sel(pdm_data_sel), .pdm_data(pdm_data),
    .gpio_out_value(gpio_out_value), .panic_flag(panic_flag), .ss_lines(ss_lines));

  mp_pin_partner far_side (.core_clk(core_clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup), .ext_val(ext_val), .ext_en(ext_en),
    .pin_in(pin_in));

  // --------------------------------------------------------------------
  // Bus and compare tasks
  // --------------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a);
    @(posedge core_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 rv = rdata;
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    if (err_total == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_reset;
    settle(1);
    chk(alt_function_enable, '0);
    chk(pin_oe, '0);
    for (int i = 0; i < NUM_PINS; i++)
    begin
      rd(MODE_BASE + 16'(i));
      chk(rv, REG_RESET);
      rd(WRITE_BASE + 16'(i));
      chk(rv, REG_RESET);
      rd(READ_BASE + 16'(i));
      chk(rv, REG_RESET);
    end
  endtask : t_reset

  task automatic t_map;
    wr(MODE_BASE + 16'd13, 16'hFFFF);
    rd(MODE_BASE + 16'd13);
    chk(rv, MODE_MASK);
    wr(MODE_BASE + 16'd13, 16'h0000);
    wr(16'hF51E, 16'hFFFF);
    rd(16'hF51E);
    chk(rv, 16'h0000);
    wr(READ_BASE, 16'h0001);
    rd(READ_BASE);
    chk(rv, 16'h0000);
  endtask : t_map

  task automatic t_func;
    logic [7:0] oe_tab;
    oe_tab = 8'b0110_1100;
    ext_en[2] <= 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      wr(MODE_BASE + 16'd2, {5'd0, 3'd3, 4'd0, 3'(c), 1'b1});
      for (int v = 0; v < 2; v++)
      begin
        gpio_out_value <= {NUM_PINS{v[0]}};
        panic_flag     <= v[0];
        ss_lines       <= v[0] ? 6'b001000 : 6'b110111;
        ext_val[2]     <= v[0];
        settle(5);
        chk(alt_function_enable[2], 1'b1);
        chk(pin_oe[2], oe_tab[c]);
        chk(pin_pullup[2], c == 2);
        chk(pdm_data_sel[2], c == 4);
        if (oe_tab[c])
          chk(pin_out[2], v[0]);
        if (c == 4)
          chk(pdm_data[2], v[0]);
        if (c == 0)
          chk(dsp_pin_value[2], v[0]);
      end
    end
    wr(MODE_BASE + 16'd2, 16'h0006);
    settle(1);
    chk(pin_oe[2], 1'b0);
    chk(alt_function_enable[2], 1'b0);
  endtask : t_func

  task automatic t_regin;
    wr(MODE_BASE + 16'd2, 16'h0003);
    ext_val[2] <= 1'b1;
    wr(WRITE_BASE + 16'd2, 16'h0000);
    settle(2);
    chk(dsp_pin_value[2], 1'b0);
    wr(WRITE_BASE + 16'd2, 16'h0001);
    settle(1);
    chk(dsp_pin_value[2], 1'b1);
    rd(WRITE_BASE + 16'd2);
    chk(rv, 16'h0000);
    wr(WRITE_BASE + 16'd2, 16'hFFFE);
    settle(1);
    chk(dsp_pin_value[2], 1'b0);
  endtask : t_regin

  task automatic t_input;
    ext_en[5]  <= 1'b1;
    ext_val[5] <= 1'b1;
    wr(MODE_BASE + 16'd5, 16'h0001);
    settle(8);
    chk(dsp_pin_value[5], 1'b1);
    rd(READ_BASE + 16'd5);
    chk(rv, 16'h0001);
    wr(MODE_BASE + 16'd5, 16'h0011);
    ext_val[5] <= 1'b0;
    settle(2900);
    chk(dsp_pin_value[5], 1'b1);
    settle(1200);
    chk(dsp_pin_value[5], 1'b0);
    rd(READ_BASE + 16'd5);
    chk(rv, 16'h0000);
    wr(MODE_BASE + 16'd5, 16'h0010);
    ext_val[5] <= 1'b1;
    settle(10);
    rd(READ_BASE + 16'd5);
    chk(rv, 16'h0000);
  endtask : t_input

  // --------------------------------------------------------------------
  // Main sequence and timeout
  // --------------------------------------------------------------------
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_map();
    t_func();
    t_regin();
    t_input();
    end_of_test();
  end
endmodule : multipurpose_pin_config_tb

//--- verilog/mp_debounce.sv
// Per-pin synchroniser and debounce filter
`timescale 1ns/100ps
module mp_debounce
  import mp_pin_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       tick,
  input  wire logic       active,
  input  wire logic [3:0] code,
  input  wire logic       pin_raw,
  output logic            level
);

  logic [2:0]       sync_q;
  logic             level_q;
  logic             level_d;
  logic [DEB_W-1:0] cnt_q;
  logic [DEB_W-1:0] cnt_d;
  deb_ticks_t       len;
  logic             agree;

  // ----------------------------------------------------------------------
  // Three-stage synchroniser; stages two and three must agree
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
      sync_q <= 3'b000;
    else
      sync_q <= {sync_q[1:0], pin_raw};
  end

  assign agree = (sync_q[1] == sync_q[2]);

  // ----------------------------------------------------------------------
  // Filter: new level accepted after stable for the chosen duration
  // ----------------------------------------------------------------------
  always_comb
  begin
    len     = deb_ticks(code);
    level_d = level_q;
    cnt_d   = cnt_q;
    if (!agree || sync_q[2] == level_q)
      cnt_d = '0;
    else if (!active || len == '0)
    begin
      level_d = sync_q[2];
      cnt_d   = '0;
    end
    else if (tick)
    begin
      // Count full ticks so the filter never runs shorter than its setting
      if (cnt_q >= len)
      begin
        level_d = sync_q[2];
        cnt_d   = '0;
      end
      else
        cnt_d = cnt_q + DEB_W'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      level_q <= 1'b0;
      cnt_q   <= '0;
    end
    else
    begin
      level_q <= level_d;
      cnt_q   <= cnt_d;
    end
  end

  assign level = level_q;

endmodule : mp_debounce

//--- verilog/mp_pin_config.sv
// Multipurpose pin configuration: registers, debounce and pin routing
`timescale 1ns/100ps
module mp_pin_config
  import mp_pin_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire logic [mp_pin_pkg::ADDR_W-1:0] addr,
  input  wire logic [mp_pin_pkg::DATA_W-1:0] wdata,
  input  wire logic                      wr_en,
  input  wire logic                      rd_en,
  output logic [mp_pin_pkg::DATA_W-1:0]  rdata,
  input  wire logic [mp_pin_pkg::NUM_PINS-1:0] pin_in,
  output logic [mp_pin_pkg::NUM_PINS-1:0] pin_out,
  output logic [mp_pin_pkg::NUM_PINS-1:0] pin_oe,
  output logic [mp_pin_pkg::NUM_PINS-1:0] pin_pullup,
  output logic [mp_pin_pkg::NUM_PINS-1:0] alt_function_enable,
  output logic [mp_pin_pkg::NUM_PINS-1:0] dsp_pin_value,
  output logic [mp_pin_pkg::NUM_PINS-1:0] pdm_data_sel,
  output logic [mp_pin_pkg::NUM_PINS-1:0] pdm_data,
  input  wire logic [mp_pin_pkg::NUM_PINS-1:0] gpio_out_value,
  input  wire logic                      panic_flag,
  input  wire logic [6:1]                ss_lines
);

  logic [15:0]         mode_q [NUM_PINS];
  logic [15:0]         mode_d [NUM_PINS];
  logic [NUM_PINS-1:0] wbit_q;
  logic [NUM_PINS-1:0] wbit_d;
  logic [NUM_PINS-1:0] rbit_q;
  logic [NUM_PINS-1:0] rbit_d;
  logic [15:0]         rdata_q;
  logic [15:0]         rdata_d;
  logic [NUM_PINS-1:0] deb_level;
  logic [NUM_PINS-1:0] deb_active;
  logic                tick;

  // Index of an address within a 14-register bank, or NUM_PINS on miss
  function automatic logic [4:0] bank_idx(input logic [15:0] a, input logic [15:0] base);
    logic [15:0] off;
    off = a - base;
    if (a >= base && off < 16'(NUM_PINS))
      bank_idx = off[4:0];
    else
      bank_idx = 5'(NUM_PINS);
  endfunction : bank_idx

  function automatic pin_function_code_t func_of(input logic [15:0] m);
    func_of = pin_function_code_t'(m[FUNC_HI:FUNC_LO]);
  endfunction : func_of

  // ----------------------------------------------------------------------
  // Timebase and debounce filters
  // ----------------------------------------------------------------------
  mp_tick_gen u_tick (
    .core_clk (core_clk),
    .reset    (reset),
    .tick     (tick)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++)
    begin : g_deb
      assign deb_active[g] = mode_q[g][EN_BIT] && func_of(mode_q[g]) == FN_INPUT;
      mp_debounce u_deb (
        .core_clk (core_clk),
        .reset    (reset),
        .tick     (tick),
        .active   (deb_active[g]),
        .code     (mode_q[g][DEB_HI:DEB_LO]),
        .pin_raw  (pin_in[g]),
        .level    (deb_level[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [4:0] mi;
    logic [4:0] wi;
    logic [4:0] ri;
    mi = bank_idx(addr, MODE_BASE);
    wi = bank_idx(addr, WRITE_BASE);
    ri = bank_idx(addr, READ_BASE);
    for (int i = 0; i < NUM_PINS; i++)
      mode_d[i] = mode_q[i];
    wbit_d  = wbit_q;
    rdata_d = REG_RESET;
    if (wr_en)
    begin
      if (mi < 5'(NUM_PINS))
        mode_d[mi[3:0]] = wdata & MODE_MASK;
      if (wi < 5'(NUM_PINS))
        wbit_d[wi[3:0]] = wdata[0];
    end
    if (rd_en)
    begin
      if (mi < 5'(NUM_PINS))
        rdata_d = mode_q[mi[3:0]];
      else if (ri < 5'(NUM_PINS))
        rdata_d = {15'h0000, rbit_q[ri[3:0]]};
      // Write bank is write-only and reads as zero
    end
  end

  // Read value follows the pin only for enabled input-configured pins
  always_comb
  begin
    rbit_d = rbit_q;
    for (int i = 0; i < NUM_PINS; i++)
      if (mode_q[i][EN_BIT] && func_of(mode_q[i]) == FN_INPUT)
        rbit_d[i] = deb_level[i];
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < NUM_PINS; i++)
        mode_q[i] <= REG_RESET;
      wbit_q  <= '0;
      rbit_q  <= '0;
      rdata_q <= REG_RESET;
    end
    else
    begin
      for (int i = 0; i < NUM_PINS; i++)
        mode_q[i] <= mode_d[i];
      wbit_q  <= wbit_d;
      rbit_q  <= rbit_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  // ----------------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      logic [2:0] ch;
      ch                     = mode_q[i][SS_HI:SS_LO];
      alt_function_enable[i] = mode_q[i][EN_BIT];
      pin_out[i]             = 1'b0;
      pin_oe[i]              = 1'b0;
      pin_pullup[i]          = 1'b0;
      dsp_pin_value[i]       = 1'b0;
      pdm_data_sel[i]        = 1'b0;
      pdm_data[i]            = 1'b0;
      if (mode_q[i][EN_BIT])
      begin
        case (func_of(mode_q[i]))
          FN_INPUT:  dsp_pin_value[i] = deb_level[i];
          FN_REG_IN: dsp_pin_value[i] = wbit_q[i];
          FN_OUT_PU:
          begin
            pin_oe[i]     = 1'b1;
            pin_out[i]    = gpio_out_value[i];
            pin_pullup[i] = 1'b1;
          end
          FN_OUT:
          begin
            pin_oe[i]  = 1'b1;
            pin_out[i] = gpio_out_value[i];
          end
          FN_PDM:
          begin
            pdm_data_sel[i] = 1'b1;
            pdm_data[i]     = deb_level[i];
          end
          FN_PANIC:
          begin
            pin_oe[i]  = 1'b1;
            pin_out[i] = panic_flag;
          end
          FN_SS:
          begin
            pin_oe[i] = 1'b1;
            if (ch <= 3'd5)
              pin_out[i] = ss_lines[3'(ch + 3'd1)];
            else
              pin_out[i] = 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_reg_in_value;
    @(posedge core_clk) disable iff (reset)
      (mode_q[2][3:0] == 4'h3) |-> (dsp_pin_value[2] == wbit_q[2]);
  endproperty
  a_reg_in_value: assert property (p_reg_in_value) else $error("reg input mismatch");

  property p_write_bit;
    @(posedge core_clk) disable iff (reset)
      (wr_en && addr == WRITE_BASE + 16'd2) |=> (wbit_q[2] == $past(wdata[0]));
  endproperty
  a_write_bit: assert property (p_write_bit) else $error("write bit not stored");

  property p_primary;
    @(posedge core_clk) disable iff (reset)
      !mode_q[0][EN_BIT] |-> (pin_oe[0] == 1'b0 && dsp_pin_value[0] == 1'b0);
  endproperty
  a_primary: assert property (p_primary) else $error("primary pin driven");

  property p_out_pu;
    @(posedge core_clk) disable iff (reset)
      (mode_q[2][3:0] == 4'h5) |-> (pin_oe[2] && pin_pullup[2]);
  endproperty
  a_out_pu: assert property (p_out_pu) else $error("pull-up output wrong");

  property p_out_nopu;
    @(posedge core_clk) disable iff (reset)
      (mode_q[2][3:0] == 4'h7) |-> (pin_oe[2] && !pin_pullup[2]);
  endproperty
  a_out_nopu: assert property (p_out_nopu) else $error("plain output wrong");

  property p_panic;
    @(posedge core_clk) disable iff (reset)
      (mode_q[2][3:0] == 4'hB) |-> (pin_out[2] == panic_flag);
  endproperty
  a_panic: assert property (p_panic) else $error("panic flag not driven");

  property p_pdm;
    @(posedge core_clk) disable iff (reset)
      (mode_q[2][3:0] == 4'h9) |-> (pdm_data_sel[2] && !pin_oe[2]);
  endproperty
  a_pdm: assert property (p_pdm) else $error("pdm routing wrong");

  property p_read_back;
    @(posedge core_clk) disable iff (reset)
      (rd_en && addr == READ_BASE) |=> (rdata == {15'h0000, $past(rbit_q[0])});
  endproperty
  a_read_back: assert property (p_read_back) else $error("read value wrong");

  property p_wo_read;
    @(posedge core_clk) disable iff (reset)
      (rd_en && addr == WRITE_BASE) |=> (rdata == 16'h0000);
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write bank readable");

  property p_ss_route;
    @(posedge core_clk) disable iff (reset)
      (mode_q[2][10:0] == 11'h30D) |-> (pin_oe[2] && pin_out[2] == ss_lines[4]);
  endproperty
  a_ss_route: assert property (p_ss_route) else $error("slave select channel wrong");

  property p_undefined;
    @(posedge core_clk) disable iff (reset)
      (mode_q[2][3:0] == 4'hF) |-> (!pin_oe[2] && !pdm_data_sel[2] && !dsp_pin_value[2]);
  endproperty
  a_undefined: assert property (p_undefined) else $error("undefined code drives pin");

  property p_pullup_only;
    @(posedge core_clk) disable iff (reset)
      (mode_q[2][3:0] != 4'h5) |-> !pin_pullup[2];
  endproperty
  a_pullup_only: assert property (p_pullup_only) else $error("stray pull-up");

  property p_read_follow;
    @(posedge core_clk) disable iff (reset)
      (mode_q[5][3:0] == 4'h1) |=> (rbit_q[5] == $past(deb_level[5]));
  endproperty
  a_read_follow: assert property (p_read_follow) else $error("read bit not following");

  property p_rdata_idle;
    @(posedge core_clk) disable iff (reset)
      !rd_en |=> (rdata == 16'h0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

endmodule : mp_pin_config

//--- verilog/mp_pin_pkg.sv
// Constants and types for the multipurpose pin configuration block
package mp_pin_pkg;

  // --------------------------------------------------------------------
  // Geometry
  // --------------------------------------------------------------------
  localparam int unsigned NUM_PINS   = 14;
  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned DATA_W     = 16;

  // --------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------
  localparam logic [15:0] MODE_BASE  = 16'hF510;
  localparam logic [15:0] WRITE_BASE = 16'hF520;
  localparam logic [15:0] READ_BASE  = 16'hF530;
  localparam logic [15:0] REG_RESET  = 16'h0000;

  // --------------------------------------------------------------------
  // Field positions in the pin function config register
  // --------------------------------------------------------------------
  localparam int unsigned EN_BIT     = 0;
  localparam int unsigned FUNC_LO    = 1;
  localparam int unsigned FUNC_HI    = 3;
  localparam int unsigned DEB_LO     = 4;
  localparam int unsigned DEB_HI     = 7;
  localparam int unsigned SS_LO      = 8;
  localparam int unsigned SS_HI      = 10;
  localparam logic [15:0] MODE_MASK  = 16'h07FF;

  // --------------------------------------------------------------------
  // Pin function codes
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    FN_INPUT    = 3'b000,
    FN_REG_IN   = 3'b001,
    FN_OUT_PU   = 3'b010,
    FN_OUT      = 3'b011,
    FN_PDM      = 3'b100,
    FN_PANIC    = 3'b101,
    FN_SS       = 3'b110,
    FN_UNDEF    = 3'b111
  } pin_function_code_t;

  // --------------------------------------------------------------------
  // Debounce durations in microseconds and cycles at 10 MHz
  // --------------------------------------------------------------------
  localparam int unsigned CLK_MHZ    = 10;
  localparam int unsigned DEB_US_1   = 300;
  localparam int unsigned DEB_US_2   = 600;
  localparam int unsigned DEB_US_3   = 900;
  localparam int unsigned DEB_US_4   = 5000;
  localparam int unsigned DEB_US_5   = 10000;
  localparam int unsigned DEB_US_6   = 20000;
  localparam int unsigned DEB_US_7   = 40000;
  localparam int unsigned TICK_US    = 100;
  localparam int unsigned TICK_CYC   = TICK_US * CLK_MHZ;
  localparam int unsigned TICK_W     = 10;
  localparam int unsigned DEB_W      = 9;

  typedef logic [DEB_W-1:0] deb_ticks_t;

  // Debounce length in 100 us ticks for a 4-bit code; zero means bypass
  function automatic deb_ticks_t deb_ticks(input logic [3:0] code);
    case (code)
      4'h1:    deb_ticks = DEB_W'(DEB_US_1 / TICK_US);
      4'h2:    deb_ticks = DEB_W'(DEB_US_2 / TICK_US);
      4'h3:    deb_ticks = DEB_W'(DEB_US_3 / TICK_US);
      4'h4:    deb_ticks = DEB_W'(DEB_US_4 / TICK_US);
      4'h5:    deb_ticks = DEB_W'(DEB_US_5 / TICK_US);
      4'h6:    deb_ticks = DEB_W'(DEB_US_6 / TICK_US);
      4'h7:    deb_ticks = DEB_W'(DEB_US_7 / TICK_US);
      default: deb_ticks = '0;
    endcase
  endfunction : deb_ticks

endpackage : mp_pin_pkg

//--- verilog/mp_tick_gen.sv
// Divider making a one-cycle tick every 100 us
`timescale 1ns/100ps
module mp_tick_gen
  import mp_pin_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset,
  output logic      tick
);

  logic [TICK_W-1:0] cnt_q;
  logic [TICK_W-1:0] cnt_d;

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  always_comb
  begin
    if (cnt_q == TICK_W'(TICK_CYC - 1))
      cnt_d = '0;
    else
      cnt_d = cnt_q + TICK_W'(1);
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign tick = (cnt_q == TICK_W'(TICK_CYC - 1));

endmodule : mp_tick_gen
